//--- atu_params.svh
// Offsets, field positions, reset values and counts for the address translation unit
`ifndef ATU_PARAMS_SVH
`define ATU_PARAMS_SVH
// APB register offsets (byte addresses)
`define ATU_OFF_CTRL      12'h000
`define ATU_OFF_ENTRY_HI  12'h004
`define ATU_OFF_LO_EVEN   12'h008
`define ATU_OFF_LO_ODD    12'h00C
`define ATU_OFF_PMASK     12'h010
`define ATU_OFF_INDEX     12'h014
`define ATU_OFF_LOCKED    12'h018
`define ATU_OFF_REPL      12'h01C
`define ATU_OFF_CONFIG    12'h020
`define ATU_OFF_STATUS    12'h024
`define ATU_OFF_RESULT    12'h028
// Control register bits
`define ATU_CTRL_FIXED    0
`define ATU_CTRL_ERRLVL   1
`define ATU_CTRL_WR_IDX   2
`define ATU_CTRL_WR_RND   3
// Status register bits
`define ATU_ST_SHUTDOWN   0
`define ATU_ST_MCHECK     1
// Entry low register fields
`define ATU_LO_GLOBAL     0
`define ATU_LO_VALID      1
`define ATU_LO_WRITE      2
`define ATU_LO_PFN_LSB    6
// Configuration cacheability fields
`define ATU_CFG_UPPER_HI  30
`define ATU_CFG_UPPER_LO  28
`define ATU_CFG_USER_HI   27
`define ATU_CFG_USER_LO   25
`define ATU_CFG_LOWK_HI   2
`define ATU_CFG_LOWK_LO   0
// Cacheability codes meaning uncached
`define ATU_CA_UNC_A      3'h2
`define ATU_CA_UNC_B      3'h7
// Page number widths, LFSR width and seed, control reset value
`define ATU_VPN_SMALL     20
`define ATU_VPN_LARGE     8
`define ATU_LFSR_W        10
`define ATU_LFSR_SEED     10'h3FF
`define ATU_CTRL_RESET    32'h0000_0002
`endif

//--- atu_pkg.sv
// Types shared by the address translation unit
package atu_pkg;
	// One buffer entry
	typedef struct packed {
		logic        init;
		logic [18:0] pair_tag;
		logic [7:0]  space_tag;
		logic [11:0] mask;
		logic        global;
		logic [19:0] pfn_even;
		logic [19:0] pfn_odd;
		logic        valid_even;
		logic        valid_odd;
		logic        write_even;
		logic        write_odd;
	} atu_entry_s;
	// Translation answer
	typedef struct packed {
		logic [31:0] phys;
		logic        uncached;
		logic        miss;
		logic        invalid;
		logic        modified;
		logic        addr_err;
	} atu_result_s;
	// Write sequencer
	typedef enum logic [1:0] {
		ATU_IDLE  = 2'b00,
		ATU_CHECK = 2'b01,
		ATU_WRITE = 2'b10
	} atu_state_e;
endpackage

//--- atu_core.sv
// Address translation unit: joint buffer and fixed mapping, APB registers
// How it works
// - Hit: page match and global or space tag
// - No matching entry raises miss
// - Eight-bit space tag from entry high register
// - Physical address is frame plus page offset
// - Page number spans 20 to 8 bits
// - Per-entry page size from mask at write
// - Match with clear valid raises invalid
// - Replacement index decrements, wraps at locked count
// - Ten-bit LFSR perturbs replacement decrement
// - Duplicate tag aborts write, sets shutdown, machine-check
// - Hidden init bit gates matching, cleared at reset
// - Fixed variant translates low kernel like buffer
// - Cacheability fields at 30:28, 27:25, 2:0
// - Codes 2 and 7 uncached, others cached
// - Fixed variant: user segment uses user field
// - Low kernel field; uncached segment always uncached
// - Fixed variant: upper kernel segments use upper field
// - Fixed variant: no translation exceptions, address errors
// - Error level makes user segment unmapped, uncached
// - Error level set by resets and NMI
// - Stored global is AND of both globals
// - Store to unwritable page raises modified
//
// Design decisions made here: the address map and the APB register port.
`include "atu_params.svh"
module atu_core
	import atu_pkg::*;
#(
	parameter int ENTRIES = 16 // Number of buffer entries
)(
	input  wire logic        CLK_I,       // Core clock, 125 MHz
	input  wire logic        SYS_RST_I,   // Power-on reset, sync, active high
	input  wire logic        WARM_RST_I,  // Warm reset, sync, active high
	input  wire logic        NMI_I,       // Non-maskable interrupt, one-cycle pulse
	input  wire logic        PSEL_I,      // APB select
	input  wire logic        PENABLE_I,   // APB enable
	input  wire logic        PWRITE_I,    // APB direction
	input  wire logic [11:0] PADDR_I,     // APB byte address
	input  wire logic [31:0] PWDATA_I,    // APB write data
	output logic             PREADY_O,    // APB ready
	output logic             PSLVERR_O,   // APB error on unmapped address or on a write to the replacement index
	output logic [31:0]      PRDATA_O,    // APB read data
	input  wire logic        REQ_I,       // Translation request
	input  wire logic [31:0] VADDR_I,     // Virtual address
	input  wire logic        STORE_I,     // Request is a store
	input  wire logic        KERNEL_I,    // Request in kernel mode
	output logic             RSP_VALID_O, // Answer valid, one cycle
	output atu_result_s      RSP_O,       // Translation answer
	output logic             MCHECK_O     // Machine-check pulse
);
	localparam int IW = $clog2(ENTRIES);

	// Registers
	logic [31:0]        ctrl_q, ctrl_d;       // Variant select, error level, write commands
	logic [31:0]        hi_q, hi_d;           // Entry high: pair tag and space tag
	logic [31:0]        lo_e_q, lo_e_d;       // Even entry low
	logic [31:0]        lo_o_q, lo_o_d;       // Odd entry low
	logic [11:0]        pmask_q, pmask_d;     // Page size mask, each set bit doubles the page size from 4 KB
	logic [IW-1:0]      index_q, index_d;     // Indexed write target
	logic [IW-1:0]      locked_q, locked_d;   // Locked entry count
	logic [IW-1:0]      repl_q, repl_d;       // Replacement index
	logic [9:0]         lfsr_q, lfsr_d;       // Perturbation source
	logic [31:0]        cfg_q, cfg_d;         // Cacheability fields
	logic [1:0]         stat_q, stat_d;       // Shutdown and machine-check flags
	atu_entry_s         ent_q [ENTRIES];      // Entry storage
	atu_entry_s         ent_new;              // Entry being written
	logic [ENTRIES-1:0] dup_hit;              // Duplicate tag per entry
	logic [ENTRIES-1:0] lk_hit;               // Lookup match per entry
	logic [IW-1:0]      wr_idx_q, wr_idx_d;   // Write target latched
	atu_state_e         st_q, st_d;           // Write sequencer
	logic               wr_en;                // Commit entry write
	logic               pready_q, pslverr_q;
	logic [31:0]        prdata_q, prdata_d;
	logic               pslverr_d;
	logic               rsp_valid_q;
	atu_result_s        rsp_q, rsp_d;
	logic               mcheck_q, mcheck_d;

	// Uncached test used by the low kernel and fixed mapping decodes
	function automatic logic ca_uncached(input logic [2:0] code);
		ca_uncached = (code == `ATU_CA_UNC_A) || (code == `ATU_CA_UNC_B);
	endfunction

	// Page-pair tag comparison under a mask; masked bits ignored
	function automatic logic tag_eq(input logic [18:0] a, input logic [18:0] b, input logic [11:0] m);
		logic [18:0] mm;
		mm = {7'h00, m};
		tag_eq = ((a ^ b) & ~mm) == 19'h0_0000;
	endfunction

	// Entry being written, global is the AND of both halves
	always_comb
	begin
		ent_new            = '0;
		ent_new.init       = 1'b1;
		ent_new.pair_tag   = hi_q[31:13];
		ent_new.space_tag  = hi_q[7:0];
		ent_new.mask       = pmask_q;
		ent_new.global     = lo_e_q[`ATU_LO_GLOBAL] & lo_o_q[`ATU_LO_GLOBAL];
		ent_new.pfn_even   = lo_e_q[`ATU_LO_PFN_LSB +: 20];
		ent_new.pfn_odd    = lo_o_q[`ATU_LO_PFN_LSB +: 20];
		ent_new.valid_even = lo_e_q[`ATU_LO_VALID];
		ent_new.valid_odd  = lo_o_q[`ATU_LO_VALID];
		ent_new.write_even = lo_e_q[`ATU_LO_WRITE];
		ent_new.write_odd  = lo_o_q[`ATU_LO_WRITE];
	end

	// Duplicate detection against every other initialised entry
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++)
		begin : g_dup
			assign dup_hit[g] = ent_q[g].init && (IW'(g) != wr_idx_q) &&
				tag_eq(ent_q[g].pair_tag, ent_new.pair_tag, ent_q[g].mask | ent_new.mask);
		end
	endgenerate

	// Lookup match per entry, kept apart so the miss check has its own view
	generate
		for (g = 0; g < ENTRIES; g++)
		begin : g_look
			assign lk_hit[g] = ent_q[g].init && tag_eq(ent_q[g].pair_tag, VADDR_I[31:13], ent_q[g].mask) &&
				(ent_q[g].global || ent_q[g].space_tag == hi_q[7:0]);
		end
	endgenerate

	// APB decode and register next values
	always_comb
	begin
		ctrl_d    = ctrl_q;
		hi_d      = hi_q;
		lo_e_d    = lo_e_q;
		lo_o_d    = lo_o_q;
		pmask_d   = pmask_q;
		index_d   = index_q;
		locked_d  = locked_q;
		cfg_d     = cfg_q;
		stat_d    = stat_q;
		prdata_d  = 32'h0000_0000;
		pslverr_d = 1'b0;
		// Write commands are one-shot
		ctrl_d[`ATU_CTRL_WR_IDX] = 1'b0;
		ctrl_d[`ATU_CTRL_WR_RND] = 1'b0;
		if (PSEL_I && PENABLE_I && !pready_q)
		begin
			case (PADDR_I)
				`ATU_OFF_CTRL:     prdata_d = ctrl_q;
				`ATU_OFF_ENTRY_HI: prdata_d = hi_q;
				`ATU_OFF_LO_EVEN:  prdata_d = lo_e_q;
				`ATU_OFF_LO_ODD:   prdata_d = lo_o_q;
				`ATU_OFF_PMASK:    prdata_d = {20'h0_0000, pmask_q};
				`ATU_OFF_INDEX:    prdata_d = 32'(index_q);
				`ATU_OFF_LOCKED:   prdata_d = 32'(locked_q);
				`ATU_OFF_REPL:     prdata_d = 32'(repl_q);
				`ATU_OFF_CONFIG:   prdata_d = cfg_q;
				`ATU_OFF_STATUS:   prdata_d = {30'h0000_0000, stat_q};
				default:           pslverr_d = 1'b1;
			endcase
			if (PWRITE_I)
			begin
				prdata_d = 32'h0000_0000;
				case (PADDR_I)
					`ATU_OFF_CTRL:     ctrl_d = PWDATA_I;
					`ATU_OFF_ENTRY_HI: hi_d = PWDATA_I;
					`ATU_OFF_LO_EVEN:  lo_e_d = PWDATA_I;
					`ATU_OFF_LO_ODD:   lo_o_d = PWDATA_I;
					`ATU_OFF_PMASK:    pmask_d = PWDATA_I[11:0];
					`ATU_OFF_INDEX:    index_d = PWDATA_I[IW-1:0];
					`ATU_OFF_LOCKED:   locked_d = PWDATA_I[IW-1:0];
					`ATU_OFF_CONFIG:   cfg_d = PWDATA_I;
					`ATU_OFF_STATUS:   stat_d = stat_q & ~PWDATA_I[1:0]; // Write one to clear
					default:           pslverr_d = 1'b1;
				endcase
			end
		end
		// Hardware set wins over a software clear
		if (st_q == ATU_CHECK && |dup_hit)
		begin
			stat_d[`ATU_ST_SHUTDOWN] = 1'b1;
			stat_d[`ATU_ST_MCHECK]   = 1'b1;
		end
		// Error level raised by warm reset or NMI
		if (WARM_RST_I || NMI_I)
			ctrl_d[`ATU_CTRL_ERRLVL] = 1'b1;
	end

	// Register bank; power-on reset also sets error level
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ctrl_q    <= `ATU_CTRL_RESET;
			hi_q      <= 32'h0000_0000;
			lo_e_q    <= 32'h0000_0000;
			lo_o_q    <= 32'h0000_0000;
			pmask_q   <= 12'h000;
			index_q   <= '0;
			locked_q  <= '0;
			cfg_q     <= 32'h0000_0000;
			stat_q    <= 2'b00;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			hi_q      <= hi_d;
			lo_e_q    <= lo_e_d;
			lo_o_q    <= lo_o_d;
			pmask_q   <= pmask_d;
			index_q   <= index_d;
			locked_q  <= locked_d;
			cfg_q     <= cfg_d;
			stat_q    <= stat_d;
			pready_q  <= PSEL_I && PENABLE_I && !pready_q; // One wait state
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// Replacement index: decrement, skip on LFSR tap, wrap at locked count
	always_comb
	begin
		lfsr_d = {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
		repl_d = repl_q;
		if (!lfsr_q[0])
		begin
			if (repl_q <= locked_q)
				repl_d = IW'(ENTRIES - 1);
			else
				repl_d = repl_q - 1'b1;
		end
		// A new locked count restarts the index at the top, so no stale index below it survives
		if (PSEL_I && PENABLE_I && PWRITE_I && !pready_q && PADDR_I == `ATU_OFF_LOCKED)
			repl_d = IW'(ENTRIES - 1);
	end

	// Write sequencer: latch target, compare, then commit or abort
	always_comb
	begin
		st_d     = st_q;
		wr_idx_d = wr_idx_q;
		wr_en    = 1'b0;
		mcheck_d = 1'b0;
		case (st_q)
			ATU_IDLE:
			begin
				if (ctrl_q[`ATU_CTRL_WR_IDX])
				begin
					wr_idx_d = index_q;
					st_d     = ATU_CHECK;
				end
				else if (ctrl_q[`ATU_CTRL_WR_RND])
				begin
					wr_idx_d = repl_q;
					st_d     = ATU_CHECK;
				end
			end
			ATU_CHECK:
			begin
				if (|dup_hit)
				begin
					mcheck_d = 1'b1; // Abort, no entry changes
					st_d     = ATU_IDLE;
				end
				else
					st_d = ATU_WRITE;
			end
			ATU_WRITE:
			begin
				wr_en = 1'b1;
				st_d  = ATU_IDLE;
			end
			default: st_d = ATU_IDLE;
		endcase
	end

	// Entry storage; init bits cleared only by power-on reset
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			st_q     <= ATU_IDLE;
			wr_idx_q <= '0;
			mcheck_q <= 1'b0;
			repl_q   <= IW'(ENTRIES - 1);
			lfsr_q   <= `ATU_LFSR_SEED;
			for (int i = 0; i < ENTRIES; i++)
				ent_q[i] <= '0;
		end
		else
		begin
			st_q     <= st_d;
			wr_idx_q <= wr_idx_d;
			mcheck_q <= mcheck_d;
			repl_q   <= repl_d;
			lfsr_q   <= lfsr_d;
			if (wr_en)
				ent_q[wr_idx_q] <= ent_new;
		end
	end

	// Lookup and segment decode
	always_comb
	begin
		logic        hit;
		logic        odd;
		logic [19:0] physical_frame_number;
		logic        v;
		logic        w;
		logic [31:0] om;
		logic        error_level_flag;
		hit   = 1'b0;
		odd   = 1'b0;
		physical_frame_number   = 20'h0_0000;
		v     = 1'b0;
		w     = 1'b0;
		om    = 32'h0000_0000;
		error_level_flag   = ctrl_q[`ATU_CTRL_ERRLVL];
		rsp_d = '0;
		for (int i = 0; i < ENTRIES; i++)
		begin
			// Match needs init, tag, and global or same space tag
			if (ent_q[i].init && tag_eq(ent_q[i].pair_tag, VADDR_I[31:13], ent_q[i].mask) &&
				(ent_q[i].global || ent_q[i].space_tag == hi_q[7:0]))
			begin
				hit = 1'b1;
				om  = {19'h0_0000, ent_q[i].mask, 1'b1} << 12 | 32'h0000_0FFF;
				odd = |(VADDR_I & (om ^ (om >> 1))); // Top bit of the pair offset picks the half
				physical_frame_number = odd ? ent_q[i].pfn_odd : ent_q[i].pfn_even;
				v   = odd ? ent_q[i].valid_odd : ent_q[i].valid_even;
				w   = odd ? ent_q[i].write_odd : ent_q[i].write_even;
			end
		end
		om = om >> 1; // Offset mask of one half-page
		rsp_d.addr_err = !KERNEL_I && VADDR_I[31];
		if (VADDR_I[31:30] == 2'b10)
		begin
			// Low kernel segments unmapped in both variants
			rsp_d.phys     = {3'b000, VADDR_I[28:0]};
			rsp_d.uncached = VADDR_I[29] || ca_uncached(cfg_q[`ATU_CFG_LOWK_HI:`ATU_CFG_LOWK_LO]);
		end
		else if (!VADDR_I[31] && error_level_flag)
		begin
			rsp_d.phys     = VADDR_I;
			rsp_d.uncached = 1'b1;
		end
		else if (ctrl_q[`ATU_CTRL_FIXED])
		begin
			// Fixed mapping: identity, no translation exceptions
			rsp_d.phys     = VADDR_I;
			rsp_d.uncached = VADDR_I[31] ? ca_uncached(cfg_q[`ATU_CFG_UPPER_HI:`ATU_CFG_UPPER_LO])
				: ca_uncached(cfg_q[`ATU_CFG_USER_HI:`ATU_CFG_USER_LO]);
		end
		else
		begin
			rsp_d.miss     = !hit;
			rsp_d.invalid  = hit && !v;
			rsp_d.modified = hit && v && STORE_I && !w;
			rsp_d.phys     = ({physical_frame_number, 12'h000} & ~om) | (VADDR_I & om);
			rsp_d.uncached = 1'b0;
		end
	end

	// Answer registered one cycle after the request
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			rsp_valid_q <= 1'b0;
			rsp_q       <= '0;
		end
		else
		begin
			rsp_valid_q <= REQ_I;
			rsp_q       <= rsp_d;
		end
	end

	assign PREADY_O    = pready_q;
	assign PSLVERR_O   = pslverr_q;
	assign PRDATA_O    = prdata_q;
	assign RSP_VALID_O = rsp_valid_q;
	assign RSP_O       = rsp_q;
	assign MCHECK_O    = mcheck_q;

	// Assertions
	dup_abort_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(st_q == ATU_CHECK && |dup_hit) |=> (MCHECK_O && stat_q[`ATU_ST_SHUTDOWN] && st_q == ATU_IDLE))
		else $error("duplicate write not aborted");
	miss_flag_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(REQ_I && !ctrl_q[`ATU_CTRL_FIXED] && !VADDR_I[31] && !ctrl_q[`ATU_CTRL_ERRLVL] &&
		!$past(wr_en)) |=> (RSP_O.miss == !$past(|lk_hit)))
		else $error("miss check failed");
	fixed_noexc_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(REQ_I && ctrl_q[`ATU_CTRL_FIXED]) |=> !(RSP_O.miss || RSP_O.invalid || RSP_O.modified))
		else $error("fixed mapping raised translation exception");
	low_kernel_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(REQ_I && VADDR_I[31:30] == 2'b10) |=> RSP_O.phys == {3'b000, $past(VADDR_I[28:0])})
		else $error("low kernel address wrong");
	uncached_seg_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(REQ_I && VADDR_I[31:29] == 3'b101) |=> RSP_O.uncached)
		else $error("uncached kernel segment cached");
	erl_user_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(REQ_I && !VADDR_I[31] && ctrl_q[`ATU_CTRL_ERRLVL]) |=> (RSP_O.uncached && !RSP_O.miss))
		else $error("error level user access mapped");
	repl_wrap_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(repl_q <= locked_q && !lfsr_q[0]) |=> repl_q == IW'(ENTRIES - 1))
		else $error("replacement index did not wrap");
	errlvl_set_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(WARM_RST_I || NMI_I) |=> ctrl_q[`ATU_CTRL_ERRLVL])
		else $error("error level not set");
endmodule

//--- atu_pipe_model.sv
// Pipeline model that issues translation requests and captures the answers
module atu_pipe_model
	import atu_pkg::*;
(
	input  wire logic        clk_i,       // Core clock
	input  wire logic        rsp_valid_i, // Answer strobe
	input  wire atu_result_s rsp_i,       // Answer
	output logic             req_o,       // Request
	output logic [31:0]      vaddr_o,     // Virtual address
	output logic             store_o,     // Store flag
	output logic             kernel_o     // Kernel mode flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet lines at time zero
	initial
	begin
		req_o = 1'h0;
		vaddr_o = 32'h0000_0000;
		store_o = 1'h0;
		kernel_o = 1'h0;
	end
	// One request; qualifiers invert on release so a stale address never looks valid
	task automatic xlate(input logic [31:0] va, input logic st, input logic kn, output atu_result_s r,
		output logic got);
		@(posedge clk_i);
		req_o <= 1'h1;
		vaddr_o <= va;
		store_o <= st;
		kernel_o <= kn;
		@(posedge clk_i);
		req_o <= 1'h0;
		vaddr_o <= ~va;
		store_o <= ~st;
		kernel_o <= ~kn;
		// Answer stands one cycle; look in its middle
		@(negedge clk_i);
		got = rsp_valid_i;
		r = rsp_i;
	endtask
endmodule

//--- tb.sv
// Self-checking testbench for the address translation unit
`include "atu_params.svh"
module tb
	import atu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0;      // Core clock
	logic        sys_rst = 1'h1;  // Power-on reset
	logic        warm_rst = 1'h0; // Warm reset
	logic        nmi = 1'h0;      // Non-maskable interrupt
	logic        psel = 1'h0;     // APB select
	logic        penable = 1'h0;  // APB enable
	logic        pwrite = 1'h0;   // APB direction
	logic [11:0] paddr = 12'h000; // APB address
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        req;
	logic [31:0] vaddr;
	logic        store;
	logic        kernel;
	logic        rsp_valid;
	atu_result_s rsp;
	logic        mcheck;
	int          mismatches = 0;
	int          checks_done = 0;
	// 125 MHz
	always #4 clk = ~clk;
	atu_core #(.ENTRIES(16)) u_atu_core (.CLK_I(clk), .SYS_RST_I(sys_rst), .WARM_RST_I(warm_rst), .NMI_I(nmi),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata), .REQ_I(req), .VADDR_I(vaddr),
		.STORE_I(store), .KERNEL_I(kernel), .RSP_VALID_O(rsp_valid), .RSP_O(rsp), .MCHECK_O(mcheck));
	atu_pipe_model u_atu_pipe_model (.clk_i(clk), .rsp_valid_i(rsp_valid), .rsp_i(rsp), .req_o(req),
		.vaddr_o(vaddr), .store_o(store), .kernel_o(kernel));
	task automatic close_out;
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// APB transfer; waits for ready under a bound, never assumes a latency
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		chk(pready, 32'h0000_0001);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		pwdata <= ~wd;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic [31:0] d;
		logic        e;
		apb(1'h1, a, v, d, e);
	endtask
	task automatic tr(input logic [31:0] va, input logic st, input logic kn, output atu_result_s r);
		logic g;
		u_atu_pipe_model.xlate(va, st, kn, r, g);
		chk(g, 32'h0000_0001);
	endtask
	// Entry write with its page mask and write command; counts machine-check pulses
	// Tags stay unique, except where the duplicate scenario clashes on purpose
	task automatic put_entry(input logic [31:0] idx, input logic [31:0] hi, input logic [31:0] lo0,
		input logic [31:0] lo1, input logic [31:0] pm, input logic [31:0] cmd, output int mc);
		wr(`ATU_OFF_ENTRY_HI, hi);
		wr(`ATU_OFF_LO_EVEN, lo0);
		wr(`ATU_OFF_LO_ODD, lo1);
		wr(`ATU_OFF_PMASK, pm);
		wr(`ATU_OFF_INDEX, idx);
		wr(`ATU_OFF_CTRL, cmd);
		mc = 0;
		repeat (6)
		begin
			@(negedge clk);
			if (mcheck === 1'h1)
				mc++;
		end
	endtask
	function automatic logic unc(input int v);
		return v == 2 || v == 7;
	endfunction
	atu_result_s r;
	logic [31:0] d;
	logic        e;
	int          mc;
	// Reset state, unmapped offset, error-level user access
	task automatic t_reset;
		apb(1'h0, `ATU_OFF_CTRL, 32'h0000_0000, d, e);
		chk(d, 32'h0000_0002);
		apb(1'h0, `ATU_OFF_RESULT, 32'h0000_0000, d, e);
		chk(e, 32'h0000_0001);
		tr(32'h0100_0ABC, 1'h0, 1'h0, r);
		chk(r.phys, 32'h0100_0ABC);
		chk(r.uncached, 32'h0000_0001);
		chk(r.miss, 32'h0000_0000);
	endtask
	// Empty buffer misses; uncached kernel segment drops top bits
	task automatic t_miss;
		wr(`ATU_OFF_CTRL, 32'h0000_0000);
		tr(32'h0100_0ABC, 1'h0, 1'h1, r);
		chk(r.miss, 32'h0000_0001);
		tr(32'hA123_4567, 1'h0, 1'h1, r);
		chk(r.phys, 32'h0123_4567);
		chk(r.uncached, 32'h0000_0001);
	endtask
	// Global entry: hit, store refusal, invalid odd half, any space tag
	task automatic t_entry;
		put_entry(32'h0000_0001, 32'h0040_2005, 32'h0048_D143, 32'h0002_AF01, 32'h0000_0000, 32'h0000_0004, mc);
		chk(32'(mc), 32'h0000_0000);
		tr(32'h0040_2ABC, 1'h0, 1'h1, r);
		chk(r.phys, 32'h1234_5ABC);
		tr(32'h0040_2ABC, 1'h1, 1'h1, r);
		chk(r.modified, 32'h0000_0001);
		tr(32'h0040_3ABC, 1'h0, 1'h1, r);
		chk(r.invalid, 32'h0000_0001);
		wr(`ATU_OFF_ENTRY_HI, 32'h0040_2006);
		tr(32'h0040_2ABC, 1'h0, 1'h1, r);
		chk(r.miss, 32'h0000_0000);
	endtask
	// Mixed globals: entry is private, so only its own space tag hits
	task automatic t_space;
		put_entry(32'h0000_0002, 32'h0080_2005, 32'h0001_DDC6, 32'h0002_2203, 32'h0000_0000, 32'h0000_0004, mc);
		wr(`ATU_OFF_ENTRY_HI, 32'h0080_2006);
		tr(32'h0080_2010, 1'h0, 1'h1, r);
		chk(r.miss, 32'h0000_0001);
		wr(`ATU_OFF_ENTRY_HI, 32'h0080_2005);
		tr(32'h0080_2010, 1'h1, 1'h1, r);
		chk(r.phys, 32'h0077_7010);
		chk(r.modified, 32'h0000_0000);
	endtask
	// Duplicate tag: abort, flags, machine check; flags clear by writing ones
	task automatic t_dup;
		put_entry(32'h0000_0003, 32'h0040_2005, 32'h0000_0003, 32'h0000_0003, 32'h0000_0000, 32'h0000_0004, mc);
		chk(32'(mc), 32'h0000_0001);
		apb(1'h0, `ATU_OFF_STATUS, 32'h0000_0000, d, e);
		chk(d, 32'h0000_0003);
		tr(32'h0040_2ABC, 1'h0, 1'h1, r);
		chk(r.phys, 32'h1234_5ABC);
		wr(`ATU_OFF_STATUS, 32'h0000_0003);
		apb(1'h0, `ATU_OFF_STATUS, 32'h0000_0000, d, e);
		chk(d, 32'h0000_0000);
	endtask
	// Replacement index never drops below the locked count
	task automatic t_repl;
		wr(`ATU_OFF_LOCKED, 32'h0000_0004);
		repeat (8)
		begin
			apb(1'h0, `ATU_OFF_REPL, 32'h0000_0000, d, e);
			chk(32'(d >= 4 && d <= 15), 32'h0000_0001);
		end
		// Random write of a 16 MB page lands above the locked entries
		put_entry(32'h0000_0000, 32'h4200_0005, 32'h0000_0001, 32'h0014_0007, 32'h0000_0FFF, 32'h0000_0008, mc);
		chk(32'(mc), 32'h0000_0000);
		tr(32'h4312_3456, 1'h0, 1'h1, r);
		chk(r.phys, 32'h0512_3456);
		tr(32'h4212_3456, 1'h0, 1'h1, r);
		chk(r.invalid, 32'h0000_0001);
		tr(32'h0040_2ABC, 1'h0, 1'h1, r);
		chk(r.phys, 32'h1234_5ABC);
	endtask
	// Fixed mapping: each field gets its own code so swapped fields show
	task automatic t_fixed;
		wr(`ATU_OFF_CTRL, 32'h0000_0001);
		for (int c = 0; c < 8; c++)
		begin
			wr(`ATU_OFF_CONFIG, (32'((c + 1) % 8) << 28) | (32'(c) << 25) | 32'((c + 3) % 8));
			tr(32'h8000_1000, 1'h0, 1'h1, r);
			chk(r.phys, 32'h0000_1000);
			chk(r.uncached, 32'(unc((c + 3) % 8)));
			chk(r.miss, 32'h0000_0000);
			tr(c[0] ? 32'hE000_0010 : 32'hC000_0010, 1'h0, 1'h1, r);
			chk(r.uncached, 32'(unc((c + 1) % 8)));
			tr(32'h0000_4000, 1'h0, 1'h0, r);
			chk(r.uncached, 32'(unc(c)));
			chk(r.miss, 32'h0000_0000);
			tr(32'hB000_0000, 1'h0, 1'h1, r);
			chk(r.uncached, 32'h0000_0001);
		end
		tr(32'h8000_0000, 1'h0, 1'h0, r);
		chk(r.addr_err, 32'h0000_0001);
		chk(r.miss, 32'h0000_0000);
	endtask
	// Warm reset and NMI both raise the error level
	task automatic t_erl_src;
		for (int k = 0; k < 2; k++)
		begin
			wr(`ATU_OFF_CTRL, 32'h0000_0000);
			apb(1'h0, `ATU_OFF_CTRL, 32'h0000_0000, d, e);
			chk(d[1], 32'h0000_0000);
			@(posedge clk);
			warm_rst <= k == 0;
			nmi <= k == 1;
			@(posedge clk);
			warm_rst <= 1'h0;
			nmi <= 1'h0;
			apb(1'h0, `ATU_OFF_CTRL, 32'h0000_0000, d, e);
			chk(d[1], 32'h0000_0001);
		end
		// Mid-run power-on reset restores the error level and forgets every entry
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		apb(1'h0, `ATU_OFF_CTRL, 32'h0000_0000, d, e);
		chk(d, 32'h0000_0002);
		wr(`ATU_OFF_CTRL, 32'h0000_0000);
		tr(32'h0040_2ABC, 1'h0, 1'h1, r);
		chk(r.miss, 32'h0000_0001);
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset();
		t_miss();
		t_entry();
		t_space();
		t_dup();
		t_repl();
		t_fixed();
		t_erl_src();
		close_out();
	end
	// Whole run is a few hundred cycles; this cuts a hang short
	initial
	begin
		#100000;
		mismatches++;
		close_out();
	end
endmodule
